//--- hdl/rcst_params.svh
// Offsets, field positions, reset values and timing counts of the RC self-tune block.
`ifndef RCST_PARAMS_SVH
`define RCST_PARAMS_SVH

`define RCST_ADDR_W          2
`define RCST_CTRL_OFS        2'h0
`define RCST_BIT_EN          15
`define RCST_BIT_SIDL        13
`define RCST_BIT_SRC         12
`define RCST_BIT_LOCK        11
`define RCST_BIT_LPOL        10
`define RCST_BIT_OOR         9
`define RCST_BIT_ORPOL       8
`define RCST_TRIM_LSB        0
`define RCST_TRIM_W          6
`define RCST_TRIM_RST        6'h00
`define RCST_REF_CYCLES      32
`define RCST_EXPECT_COUNT    7813
`define RCST_LOCK_PPT        2
`define RCST_RANGE_LIMIT     1000
`define RCST_CNT_W           16

`endif

//--- hdl/rcst_pkg.sv
// Types shared by the RC self-tune block.
`default_nettype none
package rcst_pkg;

    typedef struct packed {
        logic       self_tune_enable;
        logic       self_tune_stop_in_idle;
        logic       self_tune_reference_select;
        logic       self_tune_lock_status;
        logic       lock_interrupt_polarity;
        logic       self_tune_out_of_range_status;
        logic       out_of_range_interrupt_polarity;
        logic [5:0] rc_frequency_trim_field;
    } rcst_ctrl_t;

    typedef enum logic [1:0] {
        RCST_HALT,
        RCST_MEASURE,
        RCST_ADJUST
    } rcst_state_t;

endpackage
`default_nettype wire

//--- hdl/rcst_top.sv
// RC oscillator self-tune control register, measurement and trim loop.
//
// Implementation choices: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ns
`default_nettype none
`include "rcst_params.svh"

module rcst_top
    import rcst_pkg::*;
#(
    parameter int REF_CYCLES   = `RCST_REF_CYCLES,
    parameter int EXPECT_COUNT = `RCST_EXPECT_COUNT,
    parameter int RANGE_LIMIT  = `RCST_RANGE_LIMIT
) (
    input  wire logic                    core_clk_i,
    input  wire logic                    nrst_i,
    input  wire logic [`RCST_ADDR_W-1:0] avs_address_i,
    input  wire logic                    avs_read_i,
    input  wire logic                    avs_write_i,
    input  wire logic [15:0]             avs_writedata_i,
    input  wire logic [1:0]              avs_byteenable_i,
    output var  logic [15:0]             avs_readdata_o,
    output var  logic                    avs_waitrequest_o,
    input  wire logic                    core_idle_i,
    input  wire logic                    rc_clk_i,
    input  wire logic                    ref_clk_i,
    output var  logic [5:0]              rc_trim_o,
    output var  logic                    lock_irq_o,
    output var  logic                    out_of_range_irq_o
);

    localparam int CW      = `RCST_CNT_W;
    localparam int LOCK_TOL = (EXPECT_COUNT * `RCST_LOCK_PPT) / 1000;

    // Absolute difference of a measured count against the expected count.
    function automatic logic [CW-1:0] abs_err(input logic [CW-1:0] cnt);
        logic [CW-1:0] expv;
        expv = CW'(EXPECT_COUNT);
        abs_err = (cnt >= expv) ? cnt - expv : expv - cnt;
    endfunction

    // Reset release through two flops so every flop leaves reset on the same edge.
    logic rst_meta_n;
    logic rst_n;
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_meta_n <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_n      <= rst_meta_n;
        end
    end

    // Both oscillator pins are asynchronous; only the second stage feeds logic.
    logic [1:0] rc_sync;
    logic [1:0] ref_sync;
    logic       rc_prev;
    logic       ref_prev;
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            rc_sync  <= 2'h0;
            ref_sync <= 2'h0;
            rc_prev  <= 1'b0;
            ref_prev <= 1'b0;
        end else begin
            rc_sync  <= {rc_sync[0], rc_clk_i};
            ref_sync <= {ref_sync[0], ref_clk_i};
            rc_prev  <= rc_sync[1];
            ref_prev <= ref_sync[1];
        end
    end
    logic rc_rise;
    logic ref_rise;
    assign rc_rise  = rc_sync[1] & ~rc_prev;
    assign ref_rise = ref_sync[1] & ~ref_prev;

    // Bus slave: every access waits exactly one cycle, then completes.
    logic        wait_q;
    logic [15:0] rdata_q;
    logic        next_wait;
    logic [15:0] next_rdata;
    logic        req;
    logic        hit;
    logic        wr_done;
    rcst_ctrl_t  ctrl;

    assign req     = avs_read_i | avs_write_i;
    assign hit     = (avs_address_i == `RCST_CTRL_OFS);
    assign wr_done = avs_write_i & ~wait_q & hit;

    always_comb begin
        next_wait  = 1'b1;
        next_rdata = rdata_q;
        if (req && wait_q) begin
            next_wait  = 1'b0;
            next_rdata = 16'h0000;
            if (avs_read_i && hit) begin
                next_rdata[`RCST_BIT_EN]    = ctrl.self_tune_enable;
                next_rdata[`RCST_BIT_SIDL]  = ctrl.self_tune_stop_in_idle;
                next_rdata[`RCST_BIT_SRC]   = ctrl.self_tune_reference_select;
                next_rdata[`RCST_BIT_LOCK]  = ctrl.self_tune_lock_status;
                next_rdata[`RCST_BIT_LPOL]  = ctrl.lock_interrupt_polarity;
                next_rdata[`RCST_BIT_OOR]   = ctrl.self_tune_out_of_range_status;
                next_rdata[`RCST_BIT_ORPOL] = ctrl.out_of_range_interrupt_polarity;
                next_rdata[`RCST_TRIM_LSB +: `RCST_TRIM_W] = ctrl.rc_frequency_trim_field;
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            wait_q  <= 1'b1;
            rdata_q <= 16'h0000;
        end else begin
            wait_q  <= next_wait;
            rdata_q <= next_rdata;
        end
    end
    assign avs_waitrequest_o = wait_q;
    assign avs_readdata_o    = rdata_q;

    // Control register and tuning loop share one group since both write the trim field.
    rcst_state_t     st;
    rcst_state_t     next_st;
    rcst_ctrl_t      next_ctrl;
    logic [7:0]      ref_cnt;
    logic [7:0]      next_ref_cnt;
    logic [CW-1:0]   rc_cnt;
    logic [CW-1:0]   next_rc_cnt;
    logic            too_fast;
    logic            next_too_fast;
    logic            lock_irq_q;
    logic            oor_irq_q;
    logic            halt;
    logic            win_end;
    logic [CW-1:0]   err;

    // A reserved reference has no defined target, so the loop stays halted on it.
    assign halt = ~ctrl.self_tune_enable | ctrl.self_tune_reference_select
                | (ctrl.self_tune_stop_in_idle & core_idle_i);
    assign win_end = ref_rise && (ref_cnt == 8'(REF_CYCLES - 1));
    assign err     = abs_err(rc_cnt);

    always_comb begin
        next_st       = st;
        next_ctrl     = ctrl;
        next_ref_cnt  = ref_cnt;
        next_rc_cnt   = rc_cnt;
        next_too_fast = too_fast;
        if (wr_done && avs_byteenable_i[1]) begin
            next_ctrl.self_tune_enable       = avs_writedata_i[`RCST_BIT_EN];
            next_ctrl.self_tune_stop_in_idle = avs_writedata_i[`RCST_BIT_SIDL];
            next_ctrl.self_tune_reference_select      = avs_writedata_i[`RCST_BIT_SRC];
            next_ctrl.lock_interrupt_polarity         = avs_writedata_i[`RCST_BIT_LPOL];
            next_ctrl.out_of_range_interrupt_polarity = avs_writedata_i[`RCST_BIT_ORPOL];
        end
        if (wr_done && avs_byteenable_i[0] && !ctrl.self_tune_enable) begin
            next_ctrl.rc_frequency_trim_field = avs_writedata_i[`RCST_TRIM_LSB +: `RCST_TRIM_W];
        end
        case (st)
            RCST_HALT: begin
                next_ref_cnt = 8'h00;
                next_rc_cnt  = '0;
                if (!halt) begin
                    next_st = RCST_MEASURE;
                end
            end
            RCST_MEASURE: begin
                if (rc_rise && rc_cnt != {CW{1'b1}}) begin
                    next_rc_cnt = rc_cnt + 1'b1;
                end
                if (ref_rise) begin
                    next_ref_cnt = ref_cnt + 8'h01;
                end
                if (halt) begin
                    next_st = RCST_HALT;
                end else if (win_end) begin
                    next_ctrl.self_tune_lock_status = (err <= CW'(LOCK_TOL));
                    next_ctrl.self_tune_out_of_range_status = (err > CW'(RANGE_LIMIT));
                    next_too_fast = (rc_cnt > CW'(EXPECT_COUNT));
                    next_ref_cnt  = 8'h00;
                    next_rc_cnt   = '0;
                    if (err > CW'(RANGE_LIMIT)) begin
                        next_st = RCST_MEASURE;
                    end else if (err != '0) begin
                        next_st = RCST_ADJUST;
                    end
                end
            end
            RCST_ADJUST: begin
                // One step per window keeps the loop slow against measurement noise.
                if (too_fast && ctrl.rc_frequency_trim_field != 6'h00) begin
                    next_ctrl.rc_frequency_trim_field = ctrl.rc_frequency_trim_field - 6'h01;
                end else if (!too_fast && ctrl.rc_frequency_trim_field != 6'h3f) begin
                    next_ctrl.rc_frequency_trim_field = ctrl.rc_frequency_trim_field + 6'h01;
                end
                next_ref_cnt = 8'h00;
                next_rc_cnt  = '0;
                next_st      = halt ? RCST_HALT : RCST_MEASURE;
            end
            default: begin
                next_st = RCST_HALT;
            end
        endcase
    end

    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            st         <= RCST_HALT;
            ctrl       <= '{default: 1'b0, rc_frequency_trim_field: `RCST_TRIM_RST};
            ref_cnt    <= 8'h00;
            rc_cnt     <= '0;
            too_fast   <= 1'b0;
            lock_irq_q <= 1'b0;
            oor_irq_q  <= 1'b0;
        end else begin
            st         <= next_st;
            ctrl       <= next_ctrl;
            ref_cnt    <= next_ref_cnt;
            rc_cnt     <= next_rc_cnt;
            too_fast   <= next_too_fast;
            lock_irq_q <= next_ctrl.self_tune_lock_status ^ next_ctrl.lock_interrupt_polarity;
            oor_irq_q  <= next_ctrl.self_tune_out_of_range_status
                        ^ next_ctrl.out_of_range_interrupt_polarity;
        end
    end
    assign rc_trim_o          = ctrl.rc_frequency_trim_field;
    assign lock_irq_o         = lock_irq_q;
    assign out_of_range_irq_o = oor_irq_q;

    trim_owned_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
        (wr_done && avs_byteenable_i[0] && ctrl.self_tune_enable && st != RCST_ADJUST)
        |=> $stable(ctrl.rc_frequency_trim_field))
        else $error("Trim changed by software while self-tune enabled.");

    idle_halt_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
        (ctrl.self_tune_stop_in_idle && core_idle_i) |=> st == RCST_HALT)
        else $error("Tuning did not halt in idle.");

    ref_reserved_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
        ctrl.self_tune_reference_select |=> st == RCST_HALT)
        else $error("Tuning ran with the reserved reference.");

    lock_eval_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
        (st == RCST_MEASURE && !halt && win_end)
        |=> ctrl.self_tune_lock_status == ($past(err) <= CW'(LOCK_TOL)))
        else $error("Lock status does not match the measured error.");

    lock_irq_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
        ##1 lock_irq_o == (ctrl.self_tune_lock_status ? !ctrl.lock_interrupt_polarity
                                                      : ctrl.lock_interrupt_polarity))
        else $error("Lock interrupt level wrong for its polarity.");

    oor_skip_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
        (st == RCST_MEASURE && !halt && win_end && err > CW'(RANGE_LIMIT))
        |=> ctrl.self_tune_out_of_range_status && st != RCST_ADJUST
            ##1 $stable(ctrl.rc_frequency_trim_field) || $past(wr_done))
        else $error("Out-of-range window flagged wrong or tuned anyway.");

    oor_irq_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
        ##1 out_of_range_irq_o == (ctrl.self_tune_out_of_range_status
                                   ^ ctrl.out_of_range_interrupt_polarity))
        else $error("Out-of-range interrupt level wrong for its polarity.");

    rsvd_zero_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
        !avs_waitrequest_o |-> avs_readdata_o[14] == 1'b0 && avs_readdata_o[7:6] == 2'h0)
        else $error("Unimplemented bits read nonzero.");

    adjust_step_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
        (st == RCST_ADJUST && too_fast && ctrl.rc_frequency_trim_field != 6'h00)
        |=> ctrl.rc_frequency_trim_field == $past(ctrl.rc_frequency_trim_field) - 6'h01
            && st != RCST_ADJUST)
        else $error("Adjust did not step trim down once.");

    bus_answer_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
        (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
        else $error("Slave did not answer one cycle after a request.");

endmodule // rcst_top
`default_nettype wire

//--- bench/tb_rcst_top.sv
// Self-checking testbench for the RC oscillator self-tune block.
`timescale 1ns/1ns
`default_nettype none
`include "rcst_params.svh"

module tb_rcst_top;

    typedef struct packed {
        logic        w;
        logic [1:0]  a;
        logic [1:0]  be;
        logic [15:0] d;
        logic [15:0] e;
    } rcst_row_t;

    // Core cycles in one window of four 4000 ns reference periods.
    localparam int WIN = 4000;

    logic        core_clk_i         = 1'b0;
    logic        nrst_i             = 1'b0;
    logic [1:0]  avs_address_i      = 2'h0;
    logic        avs_read_i         = 1'b0;
    logic        avs_write_i        = 1'b0;
    logic [15:0] avs_writedata_i    = 16'h0000;
    logic [1:0]  avs_byteenable_i   = 2'h3;
    logic        core_idle_i        = 1'b0;
    logic        rc_clk_i           = 1'b0;
    logic        ref_clk_i          = 1'b0;
    logic [15:0] avs_readdata_o;
    logic        avs_waitrequest_o;
    logic [5:0]  rc_trim_o;
    logic        lock_irq_o;
    logic        out_of_range_irq_o;
    int          mismatches         = 0;
    int          cmp_count          = 0;
    // Oscillator phases in core cycles; rc_per is the rc period under test.
    int          ref_ph             = 0;
    int          rc_ph              = 0;
    int          rc_per             = 5;
    logic [15:0] q;
    logic [5:0]  t;

    // Tolerance is 1000*2/1000 = 2 counts, so a 16 ns rc period locks exactly.
    rcst_top #(.REF_CYCLES(4), .EXPECT_COUNT(1000), .RANGE_LIMIT(500)) u_rcst_top (
        .core_clk_i         (core_clk_i),
        .nrst_i             (nrst_i),
        .avs_address_i      (avs_address_i),
        .avs_read_i         (avs_read_i),
        .avs_write_i        (avs_write_i),
        .avs_writedata_i    (avs_writedata_i),
        .avs_byteenable_i   (avs_byteenable_i),
        .avs_readdata_o     (avs_readdata_o),
        .avs_waitrequest_o  (avs_waitrequest_o),
        .core_idle_i        (core_idle_i),
        .rc_clk_i           (rc_clk_i),
        .ref_clk_i          (ref_clk_i),
        .rc_trim_o          (rc_trim_o),
        .lock_irq_o         (lock_irq_o),
        .out_of_range_irq_o (out_of_range_irq_o)
    );

    initial forever #2 core_clk_i = ~core_clk_i;

    // The rc phase restarts with every reference period, so an rc edge never meets a window edge.
    always @(posedge core_clk_i) begin
        ref_ph    <= (ref_ph == 999) ? 0 : ref_ph + 1;
        rc_ph     <= (ref_ph == 999 || rc_ph >= rc_per - 1) ? 0 : rc_ph + 1;
        ref_clk_i <= (ref_ph < 500);
        rc_clk_i  <= (rc_ph >= rc_per / 2);
    end

    rcst_row_t rows [9] = '{
        '{1'b1, 2'h0, 2'h3, 16'hffff, 16'hb53f},
        '{1'b1, 2'h0, 2'h3, 16'h0000, 16'h003f},
        '{1'b1, 2'h0, 2'h3, 16'h0000, 16'h0000},
        '{1'b1, 2'h0, 2'h1, 16'h3f2a, 16'h002a},
        '{1'b1, 2'h0, 2'h2, 16'hffff, 16'hb52a},
        '{1'b1, 2'h0, 2'h3, 16'h4500, 16'h052a},
        '{1'b1, 2'h0, 2'h3, 16'h0015, 16'h0015},
        '{1'b1, 2'h1, 2'h3, 16'hffff, 16'h0000},
        '{1'b0, 2'h0, 2'h3, 16'h0000, 16'h0015}
    };

    task automatic fail(input string m);
        mismatches++;
        $display("[ERR] %0t %s", $time, m);
    endtask

    task automatic expect_true(input logic c, input string m);
        cmp_count++;
        if (c !== 1'b1) fail(m);
    endtask

    task automatic bus(input logic w, input logic [1:0] a, input logic [15:0] d,
                       input logic [1:0] be, output logic [15:0] rd);
        @(posedge core_clk_i);
        avs_read_i       <= ~w;
        avs_write_i      <= w;
        avs_address_i    <= a;
        avs_writedata_i  <= d;
        avs_byteenable_i <= be;
        // Only the watchdog ends a wait that never gets its answer.
        do begin
            @(posedge core_clk_i);
        end while (avs_waitrequest_o !== 1'b0);
        rd = avs_readdata_o;
        avs_read_i  <= 1'b0;
        avs_write_i <= 1'b0;
    endtask

    task automatic win(input int n);
        repeat (n * WIN) @(posedge core_clk_i);
    endtask

    task automatic conclude;
        $display("mismatches=%0d cmp_count=%0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // Bound over roughly 304 us of planned traffic, under 100000 core cycles.
    initial begin
        #360000;
        fail("watchdog expired");
        conclude;
    end

    initial begin
        repeat (4) @(posedge core_clk_i);
        expect_true({avs_waitrequest_o, rc_trim_o, lock_irq_o, out_of_range_irq_o} === 9'h100,
                    "outputs in reset");
        nrst_i <= 1'b1;
        repeat (3) @(posedge core_clk_i);
        for (int i = 0; i < 9; i++) begin
            if (rows[i].w) bus(1'b1, rows[i].a, rows[i].d, rows[i].be, q);
            bus(1'b0, rows[i].a, 16'h0000, 2'h3, q);
            expect_true(q === rows[i].e, "register readback");
            if (rows[i].a == 2'h0) begin
                expect_true(rc_trim_o === rows[i].e[5:0], "trim output");
                expect_true(lock_irq_o === (rows[i].e[11] ^ rows[i].e[10]), "lock irq");
                expect_true(out_of_range_irq_o === (rows[i].e[9] ^ rows[i].e[8]), "oor irq");
            end
        end
        // A slow rc clock must raise the trim while software writes stay out.
        bus(1'b1, 2'h0, 16'h8015, 2'h3, q);
        win(2);
        bus(1'b0, 2'h0, 16'h0000, 2'h3, q);
        expect_true({q[`RCST_BIT_LOCK], q[`RCST_BIT_OOR]} === 2'b00, "slow status");
        expect_true(rc_trim_o > 6'h15, "trim not raised");
        expect_true(q[5:0] === rc_trim_o, "trim readback");
        t = rc_trim_o;
        // The first window straddles the change and may still step up, so two full ones follow.
        rc_per = 3;
        win(3);
        repeat (8) @(posedge core_clk_i);
        expect_true(rc_trim_o < t, "trim not lowered");
        rc_per = 4;
        win(2);
        bus(1'b0, 2'h0, 16'h0000, 2'h3, q);
        expect_true({q[`RCST_BIT_LOCK], q[`RCST_BIT_OOR]} === 2'b10, "lock status");
        expect_true(lock_irq_o === 1'b1, "lock irq high");
        t = rc_trim_o;
        win(1);
        expect_true(rc_trim_o === t, "trim moved at lock");
        bus(1'b1, 2'h0, 16'h8400, 2'h3, q);
        bus(1'b0, 2'h0, 16'h0000, 2'h3, q);
        expect_true(lock_irq_o === 1'b0, "lock irq polarity");
        rc_per = 10;
        win(2);
        bus(1'b0, 2'h0, 16'h0000, 2'h3, q);
        expect_true({q[`RCST_BIT_LOCK], q[`RCST_BIT_OOR]} === 2'b01, "range status");
        expect_true({lock_irq_o, out_of_range_irq_o} === 2'b11, "irqs out of range");
        t = rc_trim_o;
        win(1);
        expect_true(rc_trim_o === t, "trim moved out of range");
        // Idle with stop-in-idle set freezes the trim until the core wakes.
        bus(1'b1, 2'h0, 16'ha000, 2'h3, q);
        rc_per = 5;
        core_idle_i <= 1'b1;
        win(1);
        t = rc_trim_o;
        win(2);
        expect_true(rc_trim_o === t, "trim moved in idle");
        core_idle_i <= 1'b0;
        win(2);
        expect_true(rc_trim_o > t, "trim frozen after idle");
        bus(1'b1, 2'h0, 16'h9000, 2'h3, q);
        win(1);
        t = rc_trim_o;
        win(2);
        expect_true(rc_trim_o === t, "trim moved with reserved source");
        // A reset in mid-run must clear the register and the outputs.
        nrst_i <= 1'b0;
        repeat (2) @(posedge core_clk_i);
        expect_true({avs_waitrequest_o, rc_trim_o, lock_irq_o, out_of_range_irq_o} === 9'h100,
                    "outputs in second reset");
        nrst_i <= 1'b1;
        repeat (3) @(posedge core_clk_i);
        bus(1'b0, 2'h0, 16'h0000, 2'h3, q);
        expect_true(q === 16'h0000, "register after reset");
        conclude;
    end

endmodule // tb_rcst_top
`default_nettype wire
